/* logic/spm_sequencer.sv */
`timescale 1ns/100ps

// How it works
// [R01] Lock command programs lock bits from low data
// [R02] Lock command clears on completion or timeout
// [R03] Load-program within three cycles reads lock/fuse
// [R04] Write command programs buffer into latched page
// [R05] Write command clears on completion or timeout
// [R06] Erase command erases latched page
// [R07] Erase command clears on completion or timeout
// [R08] Arm bit opens four-cycle store window
// [R09] Arm alone stores data word into buffer
// [R10] Arm stays high through erase and write
// [R11] Only five control patterns are accepted
// [R12] Target address latched at operation start
// [R13] Word field selects buffer word
// [R14] Buffer clears on write, reenable, reset
// [R15] Software writes each buffer word once
// [R16] Data memory write discards buffer load
// [R17] Software supplies clean page pointer
// [R18] Erase to section_a halts the CPU
// [R19] Write to section_a halts the CPU
// [R20] Busy flag blocks rww_section during programming
// [R21] Software reenables rww_section before use
// [R22] Ready interrupt while arm bit cleared
// [R23] Reenable command clears busy when idle
// [R24] Reenable during load discards buffer
// [R25] Programming length from configurable counter
module spm_sequencer (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [11:0]                         paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic                                instr_valid,
    input  wire logic                                instr_read,
    input  wire logic [spm_seq_pkg::ptr_bits-1:0]    instr_pointer,
    input  wire logic [15:0]                         store_data,
    input  wire logic                                data_mem_write,
    output logic      [7:0]                          read_result,
    output logic                                     read_result_valid,
    output logic                                     cpu_halt,
    output logic                                     rww_read_block,
    output logic                                     ready_irq,
    output logic                                     flash_erase_req,
    output logic                                     flash_write_req,
    output logic      [7:0]                          flash_page,
    output logic                                     lock_write_req
);

    ////////////////////////////////////////////////////////////////////////
    // State

    spm_seq_pkg::instr_s              instr;
    logic [4:0]                       cmd;
    logic                             rww_busy;
    logic                             spm_ready_ie;
    logic [31:0]                      op_cycles;
    logic [31:0]                      op_count;
    spm_seq_pkg::op_e                 op_run;
    logic [spm_seq_pkg::ptr_bits-1:0] latched_ptr;
    logic [15:0]                      page_buf [spm_seq_pkg::page_words];
    logic [spm_seq_pkg::page_words-1:0] buf_valid;
    logic [7:0]                       lock_bits;
    logic [7:0]                       fuse_lo;
    logic [7:0]                       fuse_hi;
    logic                             win_store;
    logic                             win_read;
    logic                             ctrl_wr;
    logic                             pattern_ok;
    logic                             store_hit;
    logic                             read_hit;
    logic                             op_done;
    logic                             bus_wr;
    logic                             bus_rd;
    logic [31:0]                      next_prdata;
    logic [5:0]                       buf_rd_idx;

    assign instr = '{valid: instr_valid, read: instr_read, pointer: instr_pointer};

    function automatic spm_seq_pkg::op_e decode(input logic [4:0] pat);
        unique case (pat)
            spm_seq_pkg::pat_reenable: decode = spm_seq_pkg::op_reenable;
            spm_seq_pkg::pat_lock:     decode = spm_seq_pkg::op_lock;
            spm_seq_pkg::pat_write:    decode = spm_seq_pkg::op_write;
            spm_seq_pkg::pat_erase:    decode = spm_seq_pkg::op_erase;
            spm_seq_pkg::pat_load:     decode = spm_seq_pkg::op_load;
            default:                   decode = spm_seq_pkg::op_none;
        endcase
    endfunction : decode

    function automatic logic in_rww(input logic [spm_seq_pkg::ptr_bits-1:0] ptr);
        in_rww = (ptr[spm_seq_pkg::ptr_bits-1:spm_seq_pkg::word_bits+1] <= 7'(spm_seq_pkg::rww_page_max));
    endfunction : in_rww

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    assign bus_wr  = psel && penable && pwrite;
    assign bus_rd  = psel && penable && !pwrite;
    assign ctrl_wr = bus_wr && (paddr == spm_seq_pkg::ctrl_addr);
    assign pattern_ok = (decode(pwdata[4:0]) != spm_seq_pkg::op_none) && (op_run == spm_seq_pkg::op_none)
                        && !data_mem_write; // [R11]
    assign store_hit  = instr.valid && !instr.read && win_store && (cmd != 5'h00) && (op_run == spm_seq_pkg::op_none);
    assign read_hit   = instr.valid && instr.read && win_read && (cmd == spm_seq_pkg::pat_lock); // [R03]
    assign op_done    = (op_run != spm_seq_pkg::op_none) && (op_count == 32'h1);

    arm_window_timer u_window (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (ctrl_wr && pattern_ok), // [R08]
        .stop       (store_hit || read_hit),
        .open_store (win_store),
        .open_read  (win_read)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command bits

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= spm_seq_pkg::ctrl_reset[4:0];
        end else if (ctrl_wr && pattern_ok) begin
            cmd <= pwdata[4:0]; // [R11]
        end else if (op_done) begin
            cmd <= 5'h00; // [R02] [R05] [R07] [R10]
        end else if (store_hit && decode(cmd) inside {spm_seq_pkg::op_load, spm_seq_pkg::op_reenable}) begin
            cmd <= 5'h00; // [R10]
        end else if (read_hit) begin
            cmd <= 5'h00; // [R03]
        end else if (!win_store && op_run == spm_seq_pkg::op_none && !store_hit) begin
            cmd <= 5'h00; // [R02] [R05] [R07] [R08]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spm_ready_ie <= 1'b0;
            op_cycles    <= 32'(spm_seq_pkg::prog_cycles);
        end else if (ctrl_wr) begin
            spm_ready_ie <= pwdata[spm_seq_pkg::ready_ie_bit];
        end else if (bus_wr && paddr == spm_seq_pkg::op_cycles_addr) begin
            op_cycles <= (pwdata == 32'h0) ? 32'h1 : pwdata; // [R25]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation timing and address latch

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_run      <= spm_seq_pkg::op_none;
            op_count    <= 32'h0;
            latched_ptr <= '0;
        end else if (store_hit && decode(cmd) inside {spm_seq_pkg::op_erase, spm_seq_pkg::op_write,
                                                    spm_seq_pkg::op_lock}) begin
            op_run      <= decode(cmd); // [R01] [R04] [R06]
            op_count    <= op_cycles; // [R25]
            latched_ptr <= instr.pointer; // [R12]
        end else if (op_done) begin
            op_run   <= spm_seq_pkg::op_none;
            op_count <= 32'h0;
        end else if (op_run != spm_seq_pkg::op_none) begin
            op_count <= op_count - 32'h1; // [R25]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rww_busy <= 1'b0;
        end else if (store_hit && decode(cmd) inside {spm_seq_pkg::op_erase, spm_seq_pkg::op_write}
                     && in_rww(instr.pointer)) begin
            rww_busy <= 1'b1; // [R20]
        end else if (store_hit && decode(cmd) inside {spm_seq_pkg::op_reenable, spm_seq_pkg::op_load}) begin
            rww_busy <= 1'b0; // [R23]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Temporary page buffer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_valid <= '0; // [R14]
        end else if (data_mem_write) begin
            buf_valid <= '0; // [R16]
        end else if (op_done && op_run == spm_seq_pkg::op_write) begin
            buf_valid <= '0; // [R14]
        end else if (ctrl_wr && pattern_ok && pwdata[spm_seq_pkg::reenable_bit]) begin
            buf_valid <= '0; // [R14] [R24]
        end else if (store_hit && decode(cmd) == spm_seq_pkg::op_load) begin
            buf_valid[instr.pointer[spm_seq_pkg::word_bits:1]] <= 1'b1; // [R13]
        end
    end

    always_ff @(posedge pclk) begin
        if (store_hit && decode(cmd) == spm_seq_pkg::op_load) begin
            page_buf[instr.pointer[spm_seq_pkg::word_bits:1]] <= store_data; // [R09] [R13]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock and fuse store

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_bits <= spm_seq_pkg::lock_reset;
            fuse_lo   <= spm_seq_pkg::fuse_reset;
            fuse_hi   <= spm_seq_pkg::fuse_reset;
        end else if (store_hit && decode(cmd) == spm_seq_pkg::op_lock) begin
            lock_bits <= lock_bits & (store_data[7:0] | 8'hc3); // [R01]
        end else if (bus_wr && paddr == spm_seq_pkg::fuse_addr) begin
            fuse_lo <= pwdata[7:0];
            fuse_hi <= pwdata[15:8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_result       <= 8'h00;
            read_result_valid <= 1'b0;
        end else begin
            read_result_valid <= read_hit;
            if (read_hit) begin
                unique case (instr.pointer[1:0])
                    2'h1:    read_result <= lock_bits; // [R03]
                    2'h3:    read_result <= fuse_hi;
                    default: read_result <= fuse_lo;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash side outputs

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_halt        <= 1'b0;
            rww_read_block  <= 1'b0;
            ready_irq       <= 1'b0;
            flash_erase_req <= 1'b0;
            flash_write_req <= 1'b0;
            lock_write_req  <= 1'b0;
            flash_page      <= 8'h00;
        end else begin
            cpu_halt        <= (op_run inside {spm_seq_pkg::op_erase, spm_seq_pkg::op_write})
                               && !in_rww(latched_ptr) && !op_done; // [R18] [R19]
            rww_read_block  <= rww_busy || ((op_run inside {spm_seq_pkg::op_erase, spm_seq_pkg::op_write})
                               && !op_done); // [R20]
            ready_irq       <= spm_ready_ie && (cmd[spm_seq_pkg::arm_bit] == 1'b0); // [R22]
            flash_erase_req <= (op_run == spm_seq_pkg::op_erase) && !op_done; // [R06]
            flash_write_req <= (op_run == spm_seq_pkg::op_write) && !op_done; // [R04]
            lock_write_req  <= (op_run == spm_seq_pkg::op_lock) && !op_done; // [R01]
            flash_page      <= 8'(latched_ptr[spm_seq_pkg::ptr_bits-1:spm_seq_pkg::word_bits+1]); // [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read

    assign buf_rd_idx = paddr[7:2] - 6'h07;

    always_comb begin
        next_prdata = 32'h0;
        unique case (paddr)
            spm_seq_pkg::ctrl_addr:      next_prdata = {24'h0, spm_ready_ie, rww_busy, 1'b0, cmd};
            spm_seq_pkg::op_cycles_addr: next_prdata = op_cycles;
            spm_seq_pkg::pointer_addr:   next_prdata = {18'h0, latched_ptr};
            spm_seq_pkg::status_addr:    next_prdata = {buf_valid[31:0]};
            spm_seq_pkg::lock_addr:      next_prdata = {24'h0, lock_bits};
            spm_seq_pkg::fuse_addr:      next_prdata = {16'h0, fuse_hi, fuse_lo};
            spm_seq_pkg::buf_addr:       next_prdata = {16'h0, page_buf[buf_rd_idx]};
            default:                     next_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr > spm_seq_pkg::buf_addr || paddr[1:0] != 2'b00);
        end
    end

endmodule : spm_sequencer

/* logic/spm_seq_pkg.sv */
package spm_seq_pkg;

    // Store-program control register, byte address on APB
    localparam logic [11:0] ctrl_addr      = 12'h000;
    localparam logic [11:0] op_cycles_addr = 12'h004;
    localparam logic [11:0] pointer_addr   = 12'h008;
    localparam logic [11:0] data_addr      = 12'h00c;
    localparam logic [11:0] status_addr    = 12'h010;
    localparam logic [11:0] lock_addr      = 12'h014;
    localparam logic [11:0] fuse_addr      = 12'h018;
    localparam logic [11:0] buf_addr       = 12'h01c;

    // Control register field positions
    localparam int arm_bit       = 0;
    localparam int erase_bit     = 1;
    localparam int write_bit     = 2;
    localparam int lock_bit      = 3;
    localparam int reenable_bit  = 4;
    localparam int busy_bit      = 6;
    localparam int ready_ie_bit  = 7;

    // Accepted lower-five-bit patterns
    localparam logic [4:0] pat_reenable = 5'h11;
    localparam logic [4:0] pat_lock     = 5'h09;
    localparam logic [4:0] pat_write    = 5'h05;
    localparam logic [4:0] pat_erase    = 5'h03;
    localparam logic [4:0] pat_load     = 5'h01;

    // Flash geometry
    localparam int word_bits    = 6;
    localparam int page_words   = 64;
    localparam int ptr_bits     = 14;
    localparam int rww_page_max = 8'd111;

    // Timing
    localparam int clk_mhz          = 10;
    localparam int arm_window       = 4;
    localparam int read_window      = 3;
    localparam int prog_time_us     = 3700;
    localparam int prog_cycles      = prog_time_us * clk_mhz;
    localparam logic [7:0] ctrl_reset      = 8'h00;
    localparam logic [7:0] lock_reset      = 8'hff;
    localparam logic [7:0] fuse_reset      = 8'hff;

    typedef enum logic [2:0] {
        op_none,
        op_load,
        op_erase,
        op_write,
        op_lock,
        op_reenable
    } op_e;

    typedef struct packed {
        logic                 valid;
        logic                 read;
        logic [ptr_bits-1:0]  pointer;
    } instr_s;

endpackage : spm_seq_pkg

/* logic/arm_window_timer.sv */
`timescale 1ns/100ps

module arm_window_timer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       stop,
    output logic            open_store,
    output logic            open_read
);

    logic [2:0] count;

    // Counts down remaining cycles after arming; window ends after four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 3'h0;
        end else if (start) begin
            count <= 3'(spm_seq_pkg::arm_window);
        end else if (stop) begin
            count <= 3'h0;
        end else if (count != 3'h0) begin
            count <= count - 3'h1;
        end
    end

    assign open_store = (count != 3'h0);
    assign open_read  = (count > 3'(spm_seq_pkg::arm_window - spm_seq_pkg::read_window));

endmodule : arm_window_timer

/* tb/spm_seq_asserts.sv */
`timescale 1ns/100ps

module spm_seq_checker (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       instr_valid,
    input  wire logic       instr_read,
    input  wire logic       read_result_valid,
    input  wire logic       cpu_halt,
    input  wire logic       rww_read_block,
    input  wire logic       ready_irq,
    input  wire logic       flash_erase_req,
    input  wire logic       flash_write_req,
    input  wire logic [7:0] flash_page,
    input  wire logic       lock_write_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic prog;
    assign prog = flash_erase_req | flash_write_req;

    sequence s_op_start; $rose(prog); endsequence
    sequence s_lock_start; $rose(lock_write_req); endsequence
    sequence s_load; instr_valid && instr_read; endsequence

    property p_halt_page; cpu_halt |-> flash_page > 8'd111; endproperty
    property p_rww_run; prog && flash_page <= 8'd111 |-> !cpu_halt; endproperty
    property p_rww_block; prog |-> rww_read_block; endproperty
    property p_arm_held; prog || lock_write_req |-> !ready_irq; endproperty
    property p_page_held; prog && $past(prog) |-> $stable(flash_page); endproperty
    property p_lock_alone; lock_write_req |-> !prog && !cpu_halt; endproperty
    property p_result_cause; read_result_valid |-> $past(instr_valid && instr_read); endproperty
    property p_result_pulse; s_load ##1 read_result_valid |=> !read_result_valid; endproperty
    property p_op_ends; s_op_start |-> ##[1:1000] !prog; endproperty
    property p_op_min; s_op_start |-> prog [*4]; endproperty
    property p_lock_ends; s_lock_start |-> ##[1:1000] !lock_write_req; endproperty

    a_halt_page: assert property (p_halt_page) else $error("halt on rww page");
    a_rww_run: assert property (p_rww_run) else $error("halt during rww op");
    a_rww_block: assert property (p_rww_block) else $error("rww not blocked");
    a_arm_held: assert property (p_arm_held) else $error("ready during op");
    a_page_held: assert property (p_page_held) else $error("page moved");
    a_lock_alone: assert property (p_lock_alone) else $error("lock with page op");
    a_result_cause: assert property (p_result_cause) else $error("result without load");
    a_result_pulse: assert property (p_result_pulse) else $error("result too long");
    a_op_ends: assert property (p_op_ends) else $error("op never ends");
    a_op_min: assert property (p_op_min) else $error("op too short");
    a_lock_ends: assert property (p_lock_ends) else $error("lock never ends");
endmodule : spm_seq_checker

bind spm_sequencer spm_seq_checker spm_seq_checker_inst (
    .pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .instr_read(instr_read),
    .read_result_valid(read_result_valid), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
    .ready_irq(ready_irq), .flash_erase_req(flash_erase_req), .flash_write_req(flash_write_req),
    .flash_page(flash_page), .lock_write_req(lock_write_req));

/* tb/cpu_core_model.sv */
`timescale 1ns/100ps

module cpu_core_model (
    input  wire logic                             pclk,
    output logic                                  instr_valid,
    output logic                                  instr_read,
    output logic [spm_seq_pkg::ptr_bits-1:0]      instr_pointer,
    output logic [15:0]                           store_data,
    output logic                                  data_mem_write
);
    initial begin
        instr_valid    = 1'b0;
        instr_read     = 1'b0;
        instr_pointer  = 14'h0000;
        store_data     = 16'h0000;
        data_mem_write = 1'b0;
    end

    // One store or load instruction, pointer set as software requires
    task automatic exec(input logic rd, input logic [13:0] ptr, input logic [15:0] d);
        @(posedge pclk);
        instr_valid   <= 1'b1;
        instr_read    <= rd;
        instr_pointer <= ptr;
        store_data    <= d;
        @(posedge pclk);
        instr_valid   <= 1'b0;
        instr_pointer <= ~ptr;
        store_data    <= ~d;
    endtask : exec

    task automatic mem_write();
        @(posedge pclk);
        data_mem_write <= 1'b1;
        @(posedge pclk);
        data_mem_write <= 1'b0;
    endtask : mem_write
endmodule : cpu_core_model

/* tb/testbench.sv */
`timescale 1ns/100ps

module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, slv;
    logic        instr_valid, instr_read, data_mem_write;
    logic [13:0] instr_pointer;
    logic [15:0] store_data;
    logic [7:0]  read_result, flash_page;
    logic        read_result_valid, cpu_halt, rww_read_block, ready_irq;
    logic        flash_erase_req, flash_write_req, lock_write_req;
    int          error_cnt = 0;
    int          checks = 0;
    int          cycles = 0;

    always #50 pclk = ~pclk;

    spm_sequencer spm_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_read(instr_read), .instr_pointer(instr_pointer),
        .store_data(store_data), .data_mem_write(data_mem_write), .read_result(read_result),
        .read_result_valid(read_result_valid), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
        .ready_irq(ready_irq), .flash_erase_req(flash_erase_req), .flash_write_req(flash_write_req),
        .flash_page(flash_page), .lock_write_req(lock_write_req));

    cpu_core_model cpu_inst (
        .pclk(pclk), .instr_valid(instr_valid), .instr_read(instr_read),
        .instr_pointer(instr_pointer), .store_data(store_data), .data_mem_write(data_mem_write));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk1

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask : rc

    // Control write with the ready interrupt kept enabled
    task automatic cmd(input logic [4:0] p);
        apb(1'b1, spm_seq_pkg::ctrl_addr, {24'h0, 3'b100, p});
    endtask : cmd

    function automatic logic [13:0] zp(input logic [6:0] pg, input logic [5:0] w);
        return {pg, w, 1'b0};
    endfunction : zp

    task automatic final_report();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_load();
        rc(spm_seq_pkg::ctrl_addr, {24'h0, spm_seq_pkg::ctrl_reset});
        rc(spm_seq_pkg::lock_addr, {24'h0, spm_seq_pkg::lock_reset});
        apb(1'b0, 12'h100, 32'h0);
        chk1(slv, 1'b1);
        apb(1'b1, spm_seq_pkg::op_cycles_addr, 32'h0000000c);
        cmd(5'h00);
        @(posedge pclk);
        #1 chk1(ready_irq, 1'b1);
        cmd(spm_seq_pkg::pat_load);
        cpu_inst.exec(1'b0, 14'h0001, 16'hbeef);
        cmd(spm_seq_pkg::pat_load);
        cpu_inst.exec(1'b0, zp(7'd0, 6'd5), 16'h1234);
        rc(spm_seq_pkg::status_addr, 32'h21);
        rc(spm_seq_pkg::buf_addr, 32'hbeef);
        cmd(spm_seq_pkg::pat_reenable);
        cpu_inst.exec(1'b0, 14'h0000, 16'h0000);
        rc(spm_seq_pkg::status_addr, 32'h0);
    endtask : t_reset_load

    task automatic t_refuse_window();
        logic [4:0] bad [6] = '{5'h07, 5'h0b, 5'h13, 5'h1f, 5'h02, 5'h10};
        logic [4:0] good [4] = '{5'h09, 5'h05, 5'h03, 5'h01};
        cmd(spm_seq_pkg::pat_load);
        cpu_inst.exec(1'b0, zp(7'd0, 6'd2), 16'h2222);
        foreach (bad[i]) begin
            cmd(bad[i]);
            rc(spm_seq_pkg::ctrl_addr, 32'h80);
        end
        foreach (good[i]) begin
            cmd(good[i]);
            repeat (5) @(posedge pclk);
            rc(spm_seq_pkg::ctrl_addr, 32'h80);
        end
        cpu_inst.exec(1'b0, zp(7'd0, 6'd3), 16'h3333);
        rc(spm_seq_pkg::status_addr, 32'h4);
    endtask : t_refuse_window

    task automatic t_erase_write();
        cmd(spm_seq_pkg::pat_erase);
        cpu_inst.exec(1'b0, zp(7'd3, 6'd0), 16'hffff);
        cpu_inst.exec(1'b0, zp(7'd9, 6'd0), 16'h0000);
        #1 chk1(flash_erase_req, 1'b1);
        chk({24'h0, flash_page}, 32'h3);
        chk1(rww_read_block, 1'b1);
        chk1(cpu_halt, 1'b0);
        rc(spm_seq_pkg::ctrl_addr, 32'hc3);
        repeat (60) if (flash_erase_req !== 1'b0) @(posedge pclk);
        rc(spm_seq_pkg::ctrl_addr, 32'hc0);
        cmd(spm_seq_pkg::pat_reenable);
        cpu_inst.exec(1'b0, 14'h0000, 16'h0000);
        rc(spm_seq_pkg::ctrl_addr, 32'h80);
        cmd(spm_seq_pkg::pat_load);
        cpu_inst.exec(1'b0, zp(7'd0, 6'd7), 16'h7777);
        cmd(spm_seq_pkg::pat_write);
        cpu_inst.exec(1'b0, zp(7'd120, 6'd0), 16'h0000);
        @(posedge pclk);
        #1 chk1(flash_write_req, 1'b1);
        chk1(cpu_halt, 1'b1);
        chk1(rww_read_block, 1'b1);
        chk({24'h0, flash_page}, 32'h78);
        repeat (60) if (flash_write_req !== 1'b0) @(posedge pclk);
        rc(spm_seq_pkg::status_addr, 32'h0);
        chk1(cpu_halt, 1'b0);
    endtask : t_erase_write

    task automatic t_lock_mem();
        logic [13:0] p [3] = '{14'h0001, 14'h0000, 14'h0003};
        logic [7:0]  e [3] = '{8'hc3, 8'hff, 8'hff};
        cmd(spm_seq_pkg::pat_lock);
        cpu_inst.exec(1'b0, zp(7'd5, 6'd9), 16'h77c3);
        @(posedge pclk);
        #1 chk1(lock_write_req, 1'b1);
        repeat (60) if (lock_write_req !== 1'b0) @(posedge pclk);
        rc(spm_seq_pkg::lock_addr, 32'hc3);
        foreach (p[i]) begin
            cmd(spm_seq_pkg::pat_lock);
            cpu_inst.exec(1'b1, p[i], 16'h0000);
            #1 chk1(read_result_valid, 1'b1);
            chk({24'h0, read_result}, {24'h0, e[i]});
        end
        cmd(spm_seq_pkg::pat_load);
        cpu_inst.exec(1'b0, zp(7'd0, 6'd4), 16'h4444);
        rc(spm_seq_pkg::status_addr, 32'h10);
        cpu_inst.mem_write();
        rc(spm_seq_pkg::status_addr, 32'h0);
        cmd(spm_seq_pkg::pat_load);
        cpu_inst.exec(1'b0, zp(7'd0, 6'd1), 16'h1111);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc(spm_seq_pkg::status_addr, 32'h0);
    endtask : t_lock_mem

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_load();
        t_refuse_window();
        t_erase_write();
        t_lock_mem();
        final_report();
    end
endmodule : testbench
